// [bcc_pkg.sv]
package bcc_pkg;

  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;

  // apb byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_WREG = 8'h10;
  localparam logic [7:0] OFS_BANK = 8'h14;
  localparam logic [7:0] OFS_INDEX = 8'h18;
  localparam logic [7:0] OFS_STACK = 8'h1c;
  localparam logic [7:0] OFS_SHADOW = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;

  // field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int ZERO_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ILL_BIT = 2;
  localparam int STAT_TAKEN_BIT = 3;

  // encodings
  localparam logic [7:0] OPC_BRANCH_ZERO = 8'he0;
  localparam logic [6:0] OPC_CALL = 7'h76;
  localparam logic [6:0] OPC_CLEAR_FILE = 7'h35;
  localparam logic [3:0] CALL_WORD2_PFX = 4'hf;
  localparam logic [7:0] INDEXED_MAX = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [DATA_W-1:0] CLEAR_VALUE = 8'h00;

  // program counter steps, in bytes
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] RET_OFS = 21'h000004;

  typedef enum logic [1:0] {BCC_Q1, BCC_Q2, BCC_Q3, BCC_Q4} bcc_q_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_EXEC, ST_NOP} bcc_fsm_e;
  typedef enum logic [1:0] {K_NONE, K_BZ, K_CALL, K_CLEAR_FILE_OP} bcc_kind_e;

  typedef struct packed {
    bcc_fsm_e fsm;
    bcc_kind_e kind;
    logic [31:0] instr;
    logic ext_en;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] return_stack_top;
    logic [DATA_W-1:0] wreg;
    logic [4:0] flags;
    logic [3:0] bank;
    logic [DATA_W-1:0] wreg_sh;
    logic [4:0] flags_sh;
    logic [3:0] bank_sh;
    logic [ADDR_W-1:0] index_base;
    logic [19:0] lit;
    logic taken;
    logic done;
    logic illegal;
    logic dmem_we;
    logic [ADDR_W-1:0] dmem_addr;
    logic [DATA_W-1:0] dmem_wdata;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bcc_state_s;

  localparam bcc_state_s ST_RESET = '0;
  localparam logic [1:0] Q_RESET = 2'h0;

  function automatic bcc_kind_e bcc_decode(input logic [31:0] ins);
    if (ins[15:8] == OPC_BRANCH_ZERO) begin
      return K_BZ;
    end else if (ins[15:9] == OPC_CALL && ins[31:28] == CALL_WORD2_PFX) begin
      return K_CALL;
    end else if (ins[15:9] == OPC_CLEAR_FILE) begin
      return K_CLEAR_FILE_OP;
    end
    return K_NONE;
  endfunction

endpackage

// [bcc_qphase.sv]
`timescale 1ns/1ns
`default_nettype none
module bcc_qphase
  import bcc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // quarter phase
  output var bcc_q_e q
);

  logic [1:0] q_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= Q_RESET;
    end else begin
      q_ff <= q_ff + 2'h1;
    end
  end

  assign q = bcc_q_e'(q_ff);

endmodule // bcc_qphase
`default_nettype wire

// [bcc_addr_gen.sv]
`timescale 1ns/1ns
`default_nettype none
module bcc_addr_gen
  import bcc_pkg::*;
(
  // operand fields
  input wire logic acc_sel,
  input wire logic [7:0] file_addr,
  input wire logic [3:0] bank,
  input wire logic [ADDR_W-1:0] index_base,
  input wire logic ext_en,
  // effective address
  output logic [ADDR_W-1:0] eff_addr,
  output logic indexed
);

  always_comb begin
    indexed = ext_en && !acc_sel && (file_addr <= INDEXED_MAX);
    if (indexed) begin
      eff_addr = index_base + {4'h0, file_addr};
    end else if (acc_sel) begin
      eff_addr = {bank, file_addr};
    end else if (file_addr < ACCESS_SPLIT) begin
      eff_addr = {4'h0, file_addr};
    end else begin
      eff_addr = {4'hf, file_addr};
    end
  end

endmodule // bcc_addr_gen
`default_nettype wire

// [bcc_exec_top.sv]
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bcc_exec_top
  import bcc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data memory write port
  output logic dmem_we,
  output logic [ADDR_W-1:0] dmem_addr,
  output logic [DATA_W-1:0] dmem_wdata
);

  bcc_state_s st_ff;
  bcc_state_s nxt_st;
  bcc_q_e q;
  logic [ADDR_W-1:0] clr_addr;
  logic clr_indexed;

  bcc_qphase u_qphase (
    .pclk(pclk),
    .presetn(presetn),
    .q(q)
  );

  bcc_addr_gen u_addr_gen (
    .acc_sel(st_ff.instr[8]),
    .file_addr(st_ff.instr[7:0]),
    .bank(st_ff.bank),
    .index_base(st_ff.index_base),
    .ext_en(st_ff.ext_en),
    .eff_addr(clr_addr),
    .indexed(clr_indexed)
  );

  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                    input logic [7:0] ofs);
    return pc + PC_STEP + {{12{ofs[7]}}, ofs, 1'b0};
  endfunction

  function automatic logic reg_known(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_INSTR || a == OFS_PC || a == OFS_FLAGS ||
           a == OFS_WREG || a == OFS_BANK || a == OFS_INDEX || a == OFS_STACK ||
           a == OFS_SHADOW || a == OFS_STAT;
  endfunction

  function automatic logic [31:0] read_mux(input bcc_state_s s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    unique case (a)
      OFS_CTRL: d[CTRL_EXT_BIT] = s.ext_en;
      OFS_INSTR: d = s.instr;
      OFS_PC: d[PC_W-1:0] = s.pc;
      OFS_FLAGS: d[4:0] = s.flags;
      OFS_WREG: d[DATA_W-1:0] = s.wreg;
      OFS_BANK: d[3:0] = s.bank;
      OFS_INDEX: d[ADDR_W-1:0] = s.index_base;
      OFS_STACK: d[PC_W-1:0] = s.return_stack_top;
      OFS_SHADOW: d[16:0] = {s.bank_sh, s.flags_sh, s.wreg_sh};
      OFS_STAT: begin
        d[STAT_BUSY_BIT] = s.fsm != ST_IDLE;
        d[STAT_DONE_BIT] = s.done;
        d[STAT_ILL_BIT] = s.illegal;
        d[STAT_TAKEN_BIT] = s.taken;
      end
      default: d = 32'h0;
    endcase
    return d;
  endfunction

  logic apb_access;
  logic apb_wr;
  logic busy;

  assign apb_access = psel && penable && !st_ff.pready;
  assign apb_wr = psel && penable && st_ff.pready && pwrite;
  assign busy = st_ff.fsm != ST_IDLE;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.dmem_we = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;

    // slave answers one cycle into the access phase
    if (apb_access) begin
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = !reg_known(paddr);
      nxt_st.prdata = pwrite ? 32'h0 : read_mux(st_ff, paddr);
    end

    // core state is frozen for software while an instruction runs, so
    // hardware updates never race a bus write
    if (apb_wr) begin
      unique case (paddr)
        OFS_CTRL: begin
          nxt_st.ext_en = busy ? st_ff.ext_en : pwdata[CTRL_EXT_BIT];
          if (pwdata[CTRL_GO_BIT] && !busy) begin
            nxt_st.fsm = ST_ARMED;
            nxt_st.done = 1'b0;
            nxt_st.illegal = 1'b0;
            nxt_st.taken = 1'b0;
          end
        end
        OFS_INSTR: if (!busy) nxt_st.instr = pwdata;
        OFS_PC: if (!busy) nxt_st.pc = pwdata[PC_W-1:0];
        OFS_FLAGS: if (!busy) nxt_st.flags = pwdata[4:0];
        OFS_WREG: if (!busy) nxt_st.wreg = pwdata[DATA_W-1:0];
        OFS_BANK: if (!busy) nxt_st.bank = pwdata[3:0];
        OFS_INDEX: if (!busy) nxt_st.index_base = pwdata[ADDR_W-1:0];
        default: ;
      endcase
    end

    unique case (st_ff.fsm)
      ST_IDLE: ;
      ST_ARMED: begin
        // start on a Q1 boundary
        if (q == BCC_Q4) begin
          nxt_st.fsm = ST_EXEC;
        end
      end
      ST_EXEC: begin
        unique case (q)
          BCC_Q1: begin
            nxt_st.kind = bcc_decode(st_ff.instr);
            nxt_st.lit = 20'h0;
          end
          BCC_Q2: begin
            unique case (st_ff.kind)
              K_BZ: nxt_st.lit = {{12{st_ff.instr[7]}}, st_ff.instr[7:0]};
              K_CALL: nxt_st.lit[7:0] = st_ff.instr[7:0];
              K_CLEAR_FILE_OP: nxt_st.dmem_addr = clr_addr;
              K_NONE: ;
            endcase
          end
          BCC_Q3: begin
            unique case (st_ff.kind)
              K_BZ: nxt_st.taken = st_ff.flags[ZERO_BIT];
              K_CALL: begin
                nxt_st.return_stack_top = st_ff.pc + RET_OFS;
                if (st_ff.instr[8]) begin
                  nxt_st.wreg_sh = st_ff.wreg;
                  nxt_st.flags_sh = st_ff.flags;
                  nxt_st.bank_sh = st_ff.bank;
                end // shadows hold otherwise
              end
              K_CLEAR_FILE_OP: nxt_st.dmem_wdata = CLEAR_VALUE;
              K_NONE: ;
            endcase
          end
          BCC_Q4: begin
            nxt_st.fsm = ST_IDLE;
            nxt_st.done = 1'b1;
            unique case (st_ff.kind)
              K_BZ: begin
                if (st_ff.taken) begin
                  nxt_st.pc = branch_target(st_ff.pc, st_ff.lit[7:0]);
                  nxt_st.fsm = ST_NOP;
                  nxt_st.done = 1'b0;
                end else begin
                  nxt_st.pc = st_ff.pc + PC_STEP;
                end
              end
              K_CALL: begin
                // second word read as operand only, never run on its own
                nxt_st.lit[19:8] = st_ff.instr[27:16];
                nxt_st.pc = {st_ff.instr[27:16], st_ff.lit[7:0], 1'b0};
                nxt_st.fsm = ST_NOP;
                nxt_st.done = 1'b0;
              end
              K_CLEAR_FILE_OP: begin
                nxt_st.dmem_we = 1'b1;
                nxt_st.flags[ZERO_BIT] = 1'b1;
                nxt_st.pc = st_ff.pc + PC_STEP;
              end
              K_NONE: begin
                // unknown word or call without its second word: skip it
                nxt_st.illegal = 1'b1;
                nxt_st.pc = st_ff.pc + PC_STEP;
              end
            endcase
          end
        endcase
      end
      ST_NOP: begin
        // idle second cycle of a taken branch or a call
        if (q == BCC_Q4) begin
          nxt_st.fsm = ST_IDLE;
          nxt_st.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign dmem_we = st_ff.dmem_we;
  assign dmem_addr = st_ff.dmem_addr;
  assign dmem_wdata = st_ff.dmem_wdata;

endmodule // bcc_exec_top
`default_nettype wire

// [bcc_exec_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module bcc_exec_assertions
  import bcc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // data memory
  input wire logic dmem_we,
  input wire logic [ADDR_W-1:0] dmem_addr,
  input wire logic [DATA_W-1:0] dmem_wdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable && !pready;
  ready_once_a:
    assert property (pready |=> !pready) else $error("pready held too long");
  ready_due_a:
    assert property (acc |=> pready) else $error("no pready after access");
  ready_cause_a:
    assert property (pready |-> $past(psel && penable)) else $error("pready without access");
  err_with_ready_a:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  bad_addr_a:
    assert property (acc && paddr > 8'h24 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  good_addr_a:
    assert property (acc && paddr <= 8'h24 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  clear_zero_a:
    assert property (dmem_we |-> dmem_wdata == 8'h00) else $error("clear wrote nonzero");
  we_single_a:
    assert property (dmem_we |=> !dmem_we [*3]) else $error("clear wrote twice");
  addr_hold_a:
    assert property (dmem_we |=> $stable(dmem_addr) [*3]) else $error("clear address moved");
endmodule // bcc_exec_assertions

bind bcc_exec_top bcc_exec_assertions bcc_exec_assertions_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata));
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  import bcc_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r, ins, m_sh;
  logic pready, pslverr, dmem_we, er, s, ext, tk;
  logic [ADDR_W-1:0] dmem_addr, m_ea;
  logic [DATA_W-1:0] dmem_wdata;
  logic [20:0] m_pc, m_tos;
  logic [7:0] f, w;
  logic [4:0] fl;
  logic [3:0] bk;
  logic [11:0] ix;
  logic [19:0] k;
  integer seed = 32'h050b;
  integer n_mismatch = 0;
  integer comparisons = 0;
  integer n_we = 0;
  integer m_we, i, j;

  bcc_exec_top bcc_exec_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dmem_we(dmem_we), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata));

  always #4 pclk = ~pclk;
  always @(posedge pclk) if (dmem_we === 1'b1) n_we <= n_we + 1;

  task automatic results;
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask

  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t == 20) begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic exec(input logic [31:0] x, input logic e);
    integer t;
    apb(1'b1, OFS_INSTR, x);
    apb(1'b1, OFS_CTRL, {30'h0, e, 1'b1});
    for (t = 0; t < 10; t++) begin
      apb(1'b0, OFS_STAT, 32'h0);
      if (r[1] === 1'b1) break;
    end
    if (t == 10) begin
      n_mismatch++;
      results();
    end
  endtask

  initial begin
    m_sh = 32'h0;
    m_tos = 21'h0;
    m_ea = '0;
    m_we = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, and an unmapped word at the end
    for (j = 0; j <= 40; j += 4) begin
      apb(1'b0, j[7:0], 32'h0);
      chk(r, 32'h0);
      chk({31'h0, er}, {31'h0, j == 40});
    end
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      m_pc = {r[20:1], 1'b0};
      fl = r[25:21];
      fl[2] = i[2];
      bk = r[29:26];
      r = $random(seed);
      w = r[7:0];
      f = r[15:8];
      ix = r[27:16];
      k = {r[31:28], r[15:0]};
      s = i[2];
      ext = i[3];
      tk = (i[1:0] == 2'h0) && fl[2];
      // boundary of the indexed window
      if (i[1:0] == 2'h2) f = i[2] ? 8'h5f : 8'h60;
      apb(1'b1, OFS_PC, {11'h0, m_pc});
      apb(1'b1, OFS_FLAGS, {27'h0, fl});
      apb(1'b1, OFS_WREG, {24'h0, w});
      apb(1'b1, OFS_BANK, {28'h0, bk});
      apb(1'b1, OFS_INDEX, {20'h0, ix});
      apb(1'b1, OFS_CTRL, {30'h0, ext, 1'b0});
      case (i[1:0])
        2'h0: ins = {16'h0, 8'he0, w};
        2'h1: ins = {4'hf, k[19:8], 7'h76, s, k[7:0]};
        default: ins = {16'h0, 7'h35, i[0], f};
      endcase
      exec(ins, ext);
      chk({28'h0, r[3:0]}, {28'h0, tk, 3'b010});
      if (i[1:0] == 2'h0) begin
        m_pc = m_pc + 21'h2 + (tk ? {{12{w[7]}}, w, 1'b0} : 21'h0);
      end else if (i[1:0] == 2'h1) begin
        m_tos = m_pc + 21'h4;
        m_pc = {k, 1'b0};
        if (s) m_sh = {15'h0, bk, fl, w};
      end else begin
        m_pc = m_pc + 21'h2;
        fl[2] = 1'b1;
        m_we++;
        if (!i[0] && ext && f <= 8'h5f) m_ea = ix + {4'h0, f};
        else if (!i[0]) m_ea = {(f < 8'h60) ? 4'h0 : 4'hf, f};
        else m_ea = {bk, f};
      end
      apb(1'b0, OFS_PC, 32'h0);
      chk(r, {11'h0, m_pc});
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(r, {27'h0, fl});
      apb(1'b0, OFS_STACK, 32'h0);
      chk(r, {11'h0, m_tos});
      apb(1'b0, OFS_SHADOW, 32'h0);
      chk(r, m_sh);
      chk({20'h0, dmem_addr}, {20'h0, m_ea});
      chk(n_we, m_we);
      chk({24'h0, dmem_wdata}, {24'h0, CLEAR_VALUE});
    end
    // call whose second word lacks its prefix: flagged, skipped, nothing pushed
    exec({4'h0, 12'h0, 7'h76, 1'b1, 8'h00}, 1'b0);
    chk({28'h0, r[3:0]}, 32'h6);
    m_pc = m_pc + 21'h2;
    apb(1'b0, OFS_PC, 32'h0);
    chk(r, {11'h0, m_pc});
    apb(1'b0, OFS_STACK, 32'h0);
    chk(r, {11'h0, m_tos});
    results();
  end
endmodule // tb
`default_nettype wire
